// ### rtl/adcc_regs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH
`define ADCC_OFS_PRESCALER 8'hf2
`define ADCC_OFS_CONTROL 8'hf3
`define ADCC_OFS_RESULT_LO 8'hf4
`define ADCC_OFS_RESULT_HI 8'hf5
`define ADCC_OFS_PIN_CFG 8'hf6
`define ADCC_BIT_PSEUDO_IDLE_BIT 6
`define ADCC_BIT_ENABLE 5
`define ADCC_BIT_EOC 4
`define ADCC_BIT_START 3
`define ADCC_RST_PRESCALER 5'h00
`define ADCC_RST_CONTROL 8'h00
`define ADCC_RST_PIN_CFG 8'h00
`define ADCC_RST_RESULT 10'h000
`define ADCC_ZERO_PRS_DIV 7'h40
`define ADCC_CONV_TICKS 4'hb
`define ADCC_FULL_SCALE 10'h3ff
`define ADCC_ZERO_SCALE 10'h000
`define ADCC_RSVD_READ 3'h0
`endif

// ### rtl/adcc_pkg.sv
// Types shared by the converter control block.
package adcc_pkg;
  typedef logic [9:0] adcc_result_t;
  typedef logic [2:0] adcc_chan_t;
  typedef enum logic [1:0] {ADCC_IDLE, ADCC_SAMPLE, ADCC_DECIDE} adcc_state_e;
endpackage

// ### rtl/adcc_clkdiv.sv
// Converter clock tick generator from the 5-bit prescale value.
`timescale 1ns/1ps
`include "adcc_regs.svh"
module adcc_clkdiv
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_run,
  input wire logic [4:0] i_prescale_value,
  output logic o_tick
);
  logic [6:0] cnt_ff;
  logic [6:0] nxt_cnt;
  logic [6:0] period;

  always_comb
  begin
    // A zero prescale value selects the slowest fixed divide.
    if (i_prescale_value == 5'h00)
      period = `ADCC_ZERO_PRS_DIV;
    else
      period = {1'b0, i_prescale_value, 1'b0};
    o_tick = i_run && (cnt_ff >= period - 7'h01);
    if (!i_run || o_tick)
      nxt_cnt = 7'h00;
    else
      nxt_cnt = cnt_ff + 7'h01;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      cnt_ff <= 7'h00;
    else if (i_ce)
      cnt_ff <= nxt_cnt;
  end
endmodule // adcc_clkdiv

// ### rtl/adcc_sar.sv
// Successive approximation sequencer: one sample period, ten decisions.
`timescale 1ns/1ps
`include "adcc_regs.svh"
module adcc_sar
  import adcc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic i_tick,
  input wire logic i_comp_above,
  output logic o_busy,
  output logic o_sample,
  output adcc_pkg::adcc_result_t o_trial,
  output logic o_done,
  output adcc_pkg::adcc_result_t o_result
);
  adcc_state_e state_ff, nxt_state;
  logic [3:0] bit_ff, nxt_bit;
  adcc_result_t acc_ff, nxt_acc;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_bit = bit_ff;
    nxt_acc = acc_ff;
    o_done = 1'b0;
    unique case (state_ff)
      ADCC_IDLE:
        if (i_start)
        begin
          nxt_state = ADCC_SAMPLE;
          nxt_acc = `ADCC_ZERO_SCALE;
        end
      ADCC_SAMPLE:
        if (i_tick)
        begin
          nxt_state = ADCC_DECIDE;
          nxt_bit = 4'h9;
        end
      ADCC_DECIDE:
        if (i_tick)
        begin
          // A comparator held high saturates to all ones; held low gives
          // all zeros, so out-of-range inputs never wrap.
          nxt_acc[bit_ff] = i_comp_above;
          if (bit_ff == 4'h0)
          begin
            nxt_state = ADCC_IDLE;
            o_done = 1'b1;
          end
          else
            nxt_bit = bit_ff - 4'h1;
        end
    endcase
    // Standby drops the sequence at once, so a later start finds the
    // sequencer idle instead of finishing a stale conversion.
    if (i_abort)
      nxt_state = ADCC_IDLE;
    o_trial = acc_ff;
    if (state_ff == ADCC_DECIDE)
      o_trial[bit_ff] = 1'b1;
  end

  assign o_busy = state_ff != ADCC_IDLE;
  assign o_sample = state_ff == ADCC_SAMPLE;
  assign o_result = nxt_acc;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_ff <= ADCC_IDLE;
      bit_ff <= 4'h0;
      acc_ff <= `ADCC_RST_RESULT;
    end
    else if (i_ce)
    begin
      state_ff <= nxt_state;
      bit_ff <= nxt_bit;
      acc_ff <= nxt_acc;
    end
  end
endmodule // adcc_sar

// ### rtl/adcc_top.sv
// Analog-to-digital converter control: registers, sequencing, pin routing.
//
// Functional notes
// - Writing one to control bit 3 starts one conversion on the channel.
// - Hardware clears the start bit when the conversion completes.
// - End flag (bit 4) set on valid result; only software clears it.
// - End flag and converter irq enable together request an interrupt.
// - Channel select value n picks analog input n, zero to seven.
// - Reference gives 3FFh, analog ground gives 000h, linear in between.
// - Out-of-range inputs saturate to all ones or all zeros.
// - Converter clock is peripheral clock over 2P, or over 64 at zero.
// - Enable bit 5 clear puts the converter into standby.
// - Pseudo-idle bit 6 halts the CPU during the conversion it starts.
// - Each pin config bit routes its port 1 pin to the converter.
// - Result 9-2 in high register, 1-0 in low register; reset zero.
// - Reserved prescaler and low result bits read zero; never set.
// - One conversion is one sample period plus ten decision periods.
// - Start on a channel whose pin is not configured does nothing.
// - In pseudo-idle only the end interrupt wakes; others stay pending.
`timescale 1ns/1ps
`include "adcc_regs.svh"
module adcc_top
  import adcc_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  input wire logic I_CE,
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic I_SFR_WR,
  input wire logic I_SFR_RD,
  input wire logic [7:0] I_SFR_WDATA,
  output logic [7:0] O_SFR_RDATA,
  input wire logic I_CONVERTER_IRQ_ENABLE,
  input wire logic I_OTHER_IRQ_PENDING,
  input wire logic I_COMP_ABOVE,
  output logic O_IRQ,
  output logic O_CPU_HALT,
  output logic O_WAKE,
  output logic O_CONVERTER_ENABLE,
  output logic O_SAMPLE,
  output adcc_pkg::adcc_chan_t O_MUX_SEL,
  output logic O_MUX_CONNECT,
  output adcc_pkg::adcc_result_t O_TRIAL_CODE,
  output logic [7:0] O_PIN_ANALOG_SELECT
);
  import adcc_pkg::*;

  // ---------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------
  logic [4:0] prescale_ff, nxt_prescale;
  logic [7:0] pin_cfg_ff, nxt_pin_cfg;
  logic pseudo_idle_ff, nxt_pseudo_idle;
  logic enable_ff, nxt_enable;
  logic eoc_ff, nxt_eoc;
  logic start_ff, nxt_start;
  adcc_chan_t chan_ff, nxt_chan;
  adcc_chan_t conv_chan_ff, nxt_conv_chan;
  logic halt_ff, nxt_halt;
  adcc_result_t result_ff, nxt_result;
  logic [7:0] rdata_ff, nxt_rdata;

  logic wr_ctrl;
  logic launch;
  logic abort;
  logic [7:0] routed_hit;
  logic sar_busy;
  logic sar_done;
  logic tick;
  adcc_result_t sar_result;

  assign wr_ctrl = I_SFR_WR && (I_SFR_ADDR == `ADCC_OFS_CONTROL);

  // Each channel compares the written channel field with its own index
  // and reports a hit only when its pin is routed to the converter.
  for (genvar k = 0; k < 8; k++)
  begin : g_route
    assign routed_hit[k] = pin_cfg_ff[k]
      && (I_SFR_WDATA[2:0] == 3'(k));
  end

  // A start needs the converter awake, kept awake by the same write, and
  // its channel pin set analog; a start while busy has no effect.
  assign launch = wr_ctrl && I_SFR_WDATA[`ADCC_BIT_START] && !start_ff
    && enable_ff && I_SFR_WDATA[`ADCC_BIT_ENABLE]
    && (|routed_hit);

  // Clearing the enable bit during a conversion abandons it; the
  // sequencer and the divider both return to idle.
  assign abort = wr_ctrl && !I_SFR_WDATA[`ADCC_BIT_ENABLE]
    && start_ff;

  // ---------------------------------------------------------------------
  // Converter clock and sequencer
  // ---------------------------------------------------------------------
  adcc_clkdiv u_clkdiv
  (
    .i_clk(I_CLK_SYS),
    .i_rst(I_SYS_RST),
    .i_ce(I_CE),
    .i_run(sar_busy),
    .i_prescale_value(prescale_ff),
    .o_tick(tick)
  );

  adcc_sar u_sar
  (
    .i_clk(I_CLK_SYS),
    .i_rst(I_SYS_RST),
    .i_ce(I_CE),
    .i_start(launch),
    .i_abort(abort),
    .i_tick(tick),
    .i_comp_above(I_COMP_ABOVE),
    .o_busy(sar_busy),
    .o_sample(O_SAMPLE),
    .o_trial(O_TRIAL_CODE),
    .o_done(sar_done),
    .o_result(sar_result)
  );

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  always_comb
  begin
    nxt_prescale = prescale_ff;
    nxt_pin_cfg = pin_cfg_ff;
    nxt_pseudo_idle = pseudo_idle_ff;
    nxt_enable = enable_ff;
    nxt_eoc = eoc_ff;
    nxt_start = start_ff;
    nxt_chan = chan_ff;
    nxt_conv_chan = conv_chan_ff;
    nxt_halt = halt_ff;
    nxt_result = result_ff;
    if (I_SFR_WR)
    begin
      unique case (I_SFR_ADDR)
        `ADCC_OFS_PRESCALER:
          nxt_prescale = I_SFR_WDATA[4:0];
        `ADCC_OFS_PIN_CFG:
          nxt_pin_cfg = I_SFR_WDATA;
        `ADCC_OFS_CONTROL:
        begin
          nxt_pseudo_idle = I_SFR_WDATA[`ADCC_BIT_PSEUDO_IDLE_BIT];
          nxt_enable = I_SFR_WDATA[`ADCC_BIT_ENABLE];
          // Software may only clear the end flag, never set it.
          if (!I_SFR_WDATA[`ADCC_BIT_EOC])
            nxt_eoc = 1'b0;
          // The channel field is frozen while busy so the running
          // conversion keeps its input.
          if (!start_ff)
            nxt_chan = I_SFR_WDATA[2:0];
        end
        default:
        begin
        end
      endcase
    end
    if (launch)
    begin
      nxt_start = 1'b1;
      nxt_conv_chan = I_SFR_WDATA[2:0];
      nxt_halt = I_SFR_WDATA[`ADCC_BIT_PSEUDO_IDLE_BIT];
    end
    if (sar_done)
    begin
      nxt_start = 1'b0;
      nxt_halt = 1'b0;
      nxt_result = sar_result;
      nxt_eoc = 1'b1;
    end
    // Losing power mid-conversion abandons it without a result.
    if (abort)
    begin
      nxt_start = 1'b0;
      nxt_halt = 1'b0;
    end
  end

  // Read path is registered so the data output comes from a flip-flop.
  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (I_SFR_RD)
    begin
      unique case (I_SFR_ADDR)
        `ADCC_OFS_PRESCALER:
          nxt_rdata = {`ADCC_RSVD_READ, prescale_ff};
        `ADCC_OFS_CONTROL:
          nxt_rdata = {1'b0, pseudo_idle_ff, enable_ff, eoc_ff, start_ff,
            chan_ff};
        `ADCC_OFS_RESULT_LO:
          nxt_rdata = {6'h00, result_ff[1:0]};
        `ADCC_OFS_RESULT_HI:
          nxt_rdata = result_ff[9:2];
        `ADCC_OFS_PIN_CFG:
          nxt_rdata = pin_cfg_ff;
        default:
          nxt_rdata = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      prescale_ff <= `ADCC_RST_PRESCALER;
      pin_cfg_ff <= `ADCC_RST_PIN_CFG;
      pseudo_idle_ff <= 1'b0;
      enable_ff <= 1'b0;
      eoc_ff <= 1'b0;
      start_ff <= 1'b0;
      chan_ff <= 3'h0;
      conv_chan_ff <= 3'h0;
      halt_ff <= 1'b0;
      result_ff <= `ADCC_RST_RESULT;
      rdata_ff <= 8'h00;
    end
    else if (I_CE)
    begin
      prescale_ff <= nxt_prescale;
      pin_cfg_ff <= nxt_pin_cfg;
      pseudo_idle_ff <= nxt_pseudo_idle;
      enable_ff <= nxt_enable;
      eoc_ff <= nxt_eoc;
      start_ff <= nxt_start;
      chan_ff <= nxt_chan;
      conv_chan_ff <= nxt_conv_chan;
      halt_ff <= nxt_halt;
      result_ff <= nxt_result;
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign O_SFR_RDATA = rdata_ff;
  assign O_IRQ = eoc_ff && I_CONVERTER_IRQ_ENABLE;
  assign O_CPU_HALT = halt_ff;
  // While halted only the end event may wake the CPU; other requests
  // stay pending upstream and are served once the halt drops.
  assign O_WAKE = halt_ff ? 1'b0 : I_OTHER_IRQ_PENDING;
  assign O_CONVERTER_ENABLE = enable_ff;
  assign O_MUX_SEL = conv_chan_ff;
  assign O_MUX_CONNECT = start_ff;
  assign O_PIN_ANALOG_SELECT = pin_cfg_ff;
endmodule // adcc_top

// ### verif/adcc_analog_model.sv
// Behavioural analog multiplexer and comparator facing the converter.
`timescale 1ns/1ps
module adcc_analog_model
(
  input wire logic i_clk,
  input wire logic i_connect,
  input wire logic [2:0] i_sel,
  input wire logic [9:0] i_trial,
  output logic o_above
);
  int level [8];
  logic flip = 1'b0;
  always @(posedge i_clk) flip <= !flip;
  // A released comparator has no stable answer, so it toggles each cycle.
  always_comb
    o_above = i_connect ? level[i_sel] >= int'(i_trial) : flip;
endmodule // adcc_analog_model

// ### verif/adcc_top_assertions.sv
// Port checks for the converter control top.
`timescale 1ns/1ps
module adcc_top_assertions
(
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  input wire logic I_CE,
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic I_SFR_WR,
  input wire logic I_SFR_RD,
  input wire logic [7:0] I_SFR_WDATA,
  input wire logic [7:0] O_SFR_RDATA,
  input wire logic I_CONVERTER_IRQ_ENABLE,
  input wire logic I_OTHER_IRQ_PENDING,
  input wire logic I_COMP_ABOVE,
  input wire logic O_IRQ,
  input wire logic O_CPU_HALT,
  input wire logic O_WAKE,
  input wire logic O_CONVERTER_ENABLE,
  input wire logic O_SAMPLE,
  input wire adcc_pkg::adcc_chan_t O_MUX_SEL,
  input wire logic O_MUX_CONNECT,
  input wire adcc_pkg::adcc_result_t O_TRIAL_CODE,
  input wire logic [7:0] O_PIN_ANALOG_SELECT
);
  import adcc_pkg::*;
  // ----
  // Checks
  // ----
  logic wr_ctl;
  logic go;
  assign wr_ctl = I_CE && I_SFR_WR && I_SFR_ADDR == 8'hf3;
  // A start counts only while enabled and with the write keeping it so.
  assign go = wr_ctl && I_SFR_WDATA[3] && I_SFR_WDATA[5]
    && O_CONVERTER_ENABLE && !O_MUX_CONNECT;
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_SYS_RST);
  a_start_begins: assert property (
    go && O_PIN_ANALOG_SELECT[I_SFR_WDATA[2:0]] |=> O_MUX_CONNECT)
    else $error("start not taken");
  a_unrouted_ignored: assert property (
    go && !O_PIN_ANALOG_SELECT[I_SFR_WDATA[2:0]] |=> !O_MUX_CONNECT)
    else $error("unrouted start ran");
  a_busy_keeps_sel: assert property (
    O_MUX_CONNECT && $past(O_MUX_CONNECT) |-> $stable(O_MUX_SEL))
    else $error("channel moved while busy");
  a_done_raises_irq: assert property (
    $fell(O_MUX_CONNECT) && O_CONVERTER_ENABLE && I_CONVERTER_IRQ_ENABLE
    |-> O_IRQ)
    else $error("no irq at completion");
  a_irq_gated: assert property (
    !I_CONVERTER_IRQ_ENABLE |-> !O_IRQ)
    else $error("irq while disabled");
  a_flag_holds: assert property (
    (O_IRQ && !wr_ctl) ##1 I_CONVERTER_IRQ_ENABLE |-> O_IRQ)
    else $error("flag cleared by hardware");
  a_first_trial: assert property (
    $fell(O_SAMPLE) && O_MUX_CONNECT |-> O_TRIAL_CODE == 10'h200)
    else $error("first trial not midscale");
  a_halt_no_wake: assert property (
    O_CPU_HALT |-> !O_WAKE)
    else $error("wake while halted");
endmodule // adcc_top_assertions

bind adcc_top adcc_top_assertions i_checker (.*);

// ### verif/adc_conversion_control_test.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`define CHK(n, e, a) \
  begin \
    comparisons++; \
    if ((a) !== (e)) \
    begin \
      num_errors++; \
      $display("Error %s expected %0h seen %0h", n, e, a); \
    end \
  end
module adc_conversion_control_test;
  import adcc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, irq_en = 1'b0;
  logic ce = 1'b1;
  logic other = 1'b0, above, irq, halt, wake, en, smp, conn, idle;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, pins, d;
  adcc_chan_t sel;
  adcc_result_t trial;
  logic [31:0] seed = 32'he5db;
  int num_errors = 0, comparisons = 0, cycles = 0;
  int n, lvl, ex, p, div, t0;
  int exp_q[$];
  adcc_top i_dut (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_CE(ce),
    .I_SFR_ADDR(addr), .I_SFR_WR(wr), .I_SFR_RD(rd), .I_SFR_WDATA(wdata),
    .O_SFR_RDATA(rdata), .I_CONVERTER_IRQ_ENABLE(irq_en),
    .I_OTHER_IRQ_PENDING(other), .I_COMP_ABOVE(above), .O_IRQ(irq),
    .O_CPU_HALT(halt), .O_WAKE(wake), .O_CONVERTER_ENABLE(en),
    .O_SAMPLE(smp), .O_MUX_SEL(sel), .O_MUX_CONNECT(conn),
    .O_TRIAL_CODE(trial), .O_PIN_ANALOG_SELECT(pins));
  adcc_analog_model i_model (.i_clk(clk), .i_connect(conn), .i_sel(sel),
    .i_trial(trial), .o_above(above));
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    addr = a;
    wdata = v;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(1);
    d = rdata;
  endtask
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    forever #5 clk = !clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      final_report();
    end
  end
  // ----
  // Tests
  // ----
  initial
  begin
    tick(2);
    rst = 1'b0;
    for (int a = 242; a <= 247; a++)
    begin
      rd_reg(8'(a));
      `CHK("reset value", 8'h00, d)
    end
    ce = 1'b0;
    wr_reg(8'hf6, 8'hbf);
    `CHK("frozen", 8'h00, pins)
    ce = 1'b1;
    wr_reg(8'hf6, 8'hbf);
    `CHK("pin select", 8'hbf, pins)
    wr_reg(8'hf3, 8'h20);
    `CHK("enable", 1'b1, en)
    tick(400);
    wr_reg(8'hf3, 8'h2e);
    tick(3);
    `CHK("unrouted start", 1'b0, conn)
    wr_reg(8'hf6, 8'hff);
    $display("Setup test done");
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      p = (i == 3) ? 0 : i % 4 + 1;
      div = (p == 0) ? 64 : 2 * p;
      lvl = (i < 2) ? 1023 * (1 - i) : int'(seed[11:0]) - 1536;
      exp_q.push_back((lvl < 0) ? 0 : (lvl > 1023) ? 1023 : lvl);
      i_model.level[i] = lvl;
      irq_en = seed[12] ^ i[1];
      other = 1'b1;
      idle = i[0];
      wr_reg(8'hf2, 8'(p));
      rd_reg(8'hf2);
      `CHK("prescaler", 8'(p), d & 8'h1f)
      t0 = cycles;
      wr_reg(8'hf3, {1'b0, idle, 3'b101, 3'(i)});
      `CHK("halt", idle, halt)
      `CHK("wake", !idle, wake)
      n = 0;
      while (conn === 1'b1 && n < 800)
      begin
        if (i == 2 && n == 5)
          wr_reg(8'hf3, 8'h2b);
        else
          tick(1);
        n++;
      end
      `CHK("duration", 11 * div, cycles - t0 - 1)
      `CHK("channel", 3'(i), sel)
      `CHK("irq", irq_en, irq)
      rd_reg(8'hf3);
      `CHK("control", {1'b0, idle, 3'b110, 3'(i)}, d & 8'h7f)
      ex = exp_q.pop_front();
      rd_reg(8'hf5);
      `CHK("high bits", ex[9:2], d)
      rd_reg(8'hf4);
      `CHK("low bits", ex[1:0], d[1:0])
      `CHK("halt end", 1'b0, halt)
      wr_reg(8'hf3, 8'h20);
      `CHK("irq clear", 1'b0, irq)
      $display("Conversion test %0d done", i);
    end
    wr_reg(8'hf3, 8'h28);
    tick(4);
    wr_reg(8'hf3, 8'h00);
    `CHK("abort", 1'b0, conn)
    tick(11 * div);
    rd_reg(8'hf3);
    `CHK("abort flags", 8'h00, d & 8'h7f)
    wr_reg(8'hf3, 8'h08);
    `CHK("standby start", 1'b0, conn)
    $display("Standby test done");
    final_report();
  end
endmodule // adc_conversion_control_test
